//--- rtl/dsp_pack_replicate_unit.sv
`timescale 1ns/100ps
// Overview of operation
// - round: sign-extend word, add 0x8000, take upper half
// - sign change saturates and sets flag 22
// - first source upper half, second lower
// - prepend: shift right, fill with source low bits
// - add four unsigned bytes to ten bits
// - zero-extend the ten-bit sum
// - mask bits 0..5 copy or clear fields
// - ignore mask 6..9, clear unselected bits
// - mask bit to status field mapping
// - sign-extend ten-bit immediate into both halves
// - byte immediate into all four lanes
// - source low half into both halves
// - source low byte into all lanes
// - no data-dependent exceptions raised
module dsp_pack_replicate_unit (
    input wire logic i_sys_clk, // core clock
    input wire logic i_srst, // synchronous reset, active high
    input wire logic i_ce, // clock enable, freezes state when low
    input wire logic i_issue, // operation valid this cycle
    input wire dsp_pack_pkg::op_t i_op, // operation select
    input wire logic [31:0] i_source_register, // source operand
    input wire logic [31:0] i_target_register, // target operand
    input wire logic [4:0] i_shift_amount, // prepend shift amount
    input wire logic [9:0] i_imm, // immediate or mask field
    input wire logic i_mask_default, // one-operand status read form
    input wire logic i_status_wr, // external write of status register
    input wire logic [31:0] i_status_wdata, // external write data
    output logic o_wb_valid, // write-back valid
    output logic [31:0] o_wb_data, // write-back value
    output logic [31:0] o_dsp_status_control // status/control register
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wb_valid;
        logic [31:0] wb_data;
        logic [31:0] status;
    } state_t;

    state_t st;
    state_t next_st;
    logic [31:0] lane_word [2];
    logic [15:0] lane_half [2];
    logic lane_sat [2];
    logic [9:0] byte_lane [4];
    logic [9:0] byte_sum;
    logic [15:0] imm_half;
    logic [31:0] imm_half_rep;
    logic [31:0] imm_byte_rep;
    logic [31:0] reg_half_rep;
    logic [31:0] reg_byte_rep;
    logic [63:0] prepend_cat;
    logic [31:0] prepend_word;
    logic [9:0] mask;
    logic [31:0] field_sel;
    logic [31:0] status_view;
    logic [31:0] result;
    logic set_flag;

    // ----------------------------------------------------------------
    // rounding lanes
    // ----------------------------------------------------------------
    // lane 1 rounds the first source into the upper half, lane 0 the second
    assign lane_word[1] = i_source_register;
    assign lane_word[0] = i_target_register;

    // one rounding and saturating lane per source word
    generate
        for (genvar lane = 0; lane < 2; lane++) begin : g_round_lane
            dsp_round_sat_lane u_lane (
                .i_word(lane_word[lane]),
                .o_half(lane_half[lane]),
                .o_sat(lane_sat[lane])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // byte reduction
    // ----------------------------------------------------------------
    // every byte is widened to ten bits first, so four of them cannot wrap
    generate
        for (genvar b = 0; b < 4; b++) begin : g_byte_lane
            assign byte_lane[b] = {2'b00, i_source_register[8 * b +: 8]};
        end
    endgenerate

    // unsigned sum of the four lanes, at most ten bits wide
    assign byte_sum = byte_lane[0] + byte_lane[1] + byte_lane[2] + byte_lane[3];

    // ----------------------------------------------------------------
    // replication
    // ----------------------------------------------------------------
    // immediate forms: the halfword form sign-extends, the byte form does not
    assign imm_half = {{6{i_imm[9]}}, i_imm};
    assign imm_half_rep = {2{imm_half}};
    assign imm_byte_rep = {4{i_imm[7:0]}};

    // register forms: only the low halfword or the low byte of the source is used
    assign reg_half_rep = {2{i_source_register[15:0]}};
    assign reg_byte_rep = {4{i_source_register[7:0]}};

    // ----------------------------------------------------------------
    // prepend
    // ----------------------------------------------------------------
    // the source sits above the target, so its low bits drop into the
    // positions that the right shift empties; a zero shift keeps the target
    assign prepend_cat = {i_source_register, i_target_register} >> i_shift_amount;
    assign prepend_word = prepend_cat[31:0];

    // ----------------------------------------------------------------
    // masked status read
    // ----------------------------------------------------------------
    // the one-operand form selects every field but the extract-fail bit
    assign mask = i_mask_default ? dsp_pack_pkg::MASK_ALL_FIELDS : i_imm;

    // bit mask of every selected field; mask bits 9..6 select nothing
    always_comb begin
        field_sel = 32'h0000_0000;
        if (mask[0]) begin
            field_sel[dsp_pack_pkg::POS_MSB:dsp_pack_pkg::POS_LSB] = 6'h3F;
        end
        if (mask[1]) begin
            field_sel[dsp_pack_pkg::SCOUNT_MSB:dsp_pack_pkg::SCOUNT_LSB] = 6'h3F;
        end
        if (mask[2]) begin
            field_sel[dsp_pack_pkg::CARRY_BIT] = 1'b1;
        end
        if (mask[3]) begin
            field_sel[dsp_pack_pkg::OUFLAG_MSB:dsp_pack_pkg::OUFLAG_LSB] = 8'hFF;
        end
        if (mask[4]) begin
            field_sel[dsp_pack_pkg::CCOND_MSB:dsp_pack_pkg::CCOND_LSB] = 4'hF;
        end
        if (mask[5]) begin
            field_sel[dsp_pack_pkg::EFI_BIT] = 1'b1;
        end
    end

    // the status word as held before this edge, reduced to selected fields
    assign status_view = st.status & field_sel;

    // ----------------------------------------------------------------
    // result selection
    // ----------------------------------------------------------------
    // one full destination value per operation for the write-back
    always_comb begin
        result = 32'h0000_0000;
        set_flag = 1'b0;
        case (i_op)
            dsp_pack_pkg::OP_ROUND_SAT_REDUCE: begin
                result = {lane_half[1], lane_half[0]};
                set_flag = lane_sat[0] | lane_sat[1];
            end
            dsp_pack_pkg::OP_EXTRACT_WORD: begin
                result = prepend_word;
            end
            dsp_pack_pkg::OP_BYTE_REDUCTION_ADD: begin
                result = {22'h00_0000, byte_sum};
            end
            dsp_pack_pkg::OP_MASKED_STATUS_READ: begin
                result = status_view;
            end
            dsp_pack_pkg::OP_HALFWORD_IMM_REPLICATE: begin
                result = imm_half_rep;
            end
            dsp_pack_pkg::OP_BYTE_IMM_REPLICATE: begin
                result = imm_byte_rep;
            end
            dsp_pack_pkg::OP_HALFWORD_REG_REPLICATE: begin
                result = reg_half_rep;
            end
            dsp_pack_pkg::OP_BYTE_REG_REPLICATE: begin
                result = reg_byte_rep;
            end
            default: begin
                result = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // next state: write-back and flag update, no trap path exists
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.wb_valid = i_issue;
        if (i_issue) begin
            next_st.wb_data = result;
        end
        if (i_status_wr) begin
            next_st.status = i_status_wdata;
        end
        // set wins over a simultaneous external write; only that external write clears it here
        if (i_issue && set_flag) begin
            next_st.status[dsp_pack_pkg::SAT_FLAG_BIT] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st <= '{wb_valid: 1'b0, wb_data: 32'h0000_0000,
                    status: dsp_pack_pkg::STATUS_RESET};
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // every output comes straight from the state register
    assign o_wb_valid = st.wb_valid;
    assign o_wb_data = st.wb_data;
    assign o_dsp_status_control = st.status;
endmodule

//--- rtl/dsp_pack_pkg.sv
package dsp_pack_pkg;

    // ----------------------------------------------------------------
    // operation select
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_ROUND_SAT_REDUCE = 3'h0,
        OP_EXTRACT_WORD = 3'h1,
        OP_BYTE_REDUCTION_ADD = 3'h2,
        OP_MASKED_STATUS_READ = 3'h3,
        OP_HALFWORD_IMM_REPLICATE = 3'h4,
        OP_BYTE_IMM_REPLICATE = 3'h5,
        OP_HALFWORD_REG_REPLICATE = 3'h6,
        OP_BYTE_REG_REPLICATE = 3'h7
    } op_t;

    // ----------------------------------------------------------------
    // rounding constants
    // ----------------------------------------------------------------
    localparam logic [32:0] ROUND_CONST = 33'h0_0000_8000;
    localparam logic [32:0] SAT_MAX_Q31 = 33'h0_7FFF_FFFF;

    // ----------------------------------------------------------------
    // status/control field layout
    // ----------------------------------------------------------------
    localparam int POS_LSB = 0;
    localparam int POS_MSB = 5;
    localparam int SCOUNT_LSB = 7;
    localparam int SCOUNT_MSB = 12;
    localparam int CARRY_BIT = 13;
    localparam int EFI_BIT = 14;
    localparam int OUFLAG_LSB = 16;
    localparam int OUFLAG_MSB = 23;
    localparam int CCOND_LSB = 24;
    localparam int CCOND_MSB = 27;
    localparam int SAT_FLAG_BIT = 22;
    localparam int MASK_USED_BITS = 6;
    localparam logic [9:0] MASK_ALL_FIELDS = 10'h01F;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

endpackage

//--- rtl/dsp_round_sat_lane.sv
`timescale 1ns/100ps
module dsp_round_sat_lane (
    input wire logic [31:0] i_word, // q31 input word
    output logic [15:0] o_half, // rounded, saturated q15
    output logic o_sat // saturation happened
);
    logic [32:0] rounded;

    // ----------------------------------------------------------------
    // sign-extend, round, saturate
    // ----------------------------------------------------------------
    always_comb begin
        rounded = {i_word[31], i_word} + dsp_pack_pkg::ROUND_CONST;
        o_sat = rounded[32] != rounded[31];
        if (o_sat) begin
            rounded = dsp_pack_pkg::SAT_MAX_Q31;
        end
        o_half = rounded[31:16];
    end
endmodule

//--- testbench/dsp_pack_props.sv
`timescale 1ns/100ps
module dsp_pack_props (
    input wire logic i_sys_clk, // clock
    input wire logic i_srst, // reset
    input wire logic i_ce, // enable
    input wire logic i_issue, // op valid
    input wire dsp_pack_pkg::op_t i_op, // op
    input wire logic [31:0] i_source_register, // source
    input wire logic [9:0] i_imm, // immediate
    input wire logic i_status_wr, // status write
    input wire logic o_wb_valid, // result valid
    input wire logic [31:0] o_wb_data, // result
    input wire logic [31:0] o_dsp_status_control // status
);
    logic [31:0] s;
    logic [9:0] m;
    wire take = i_ce && i_issue;
    wire [2:0] op = i_op;
    // operands of the op taken at each edge
    always_ff @(posedge i_sys_clk) {s, m} <= {i_source_register, i_imm};
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    a_valid_after_issue: assert property (take |=> o_wb_valid)
        else $error("no write-back");
    a_byte_reg_fill: assert property (take && op == 3'h7 |=>
        o_wb_data == {4{s[7:0]}}) else $error("byte lanes wrong");
    a_half_imm_fill: assert property (take && op == 3'h4 |=>
        o_wb_data == {2{{6{m[9]}}, m}}) else $error("halfword imm wrong");
    a_byte_imm_fill: assert property (take && op == 3'h5 |=>
        o_wb_data == {4{m[7:0]}}) else $error("byte imm wrong");
    a_sum_zero_ext: assert property (take && op == 3'h2 |=>
        o_wb_data == {22'h00_0000, 10'(s[31:24]) + 10'(s[23:16]) + 10'(s[15:8]) + 10'(s[7:0])})
        else $error("sum wrong");
    a_read_clears: assert property (take && op == 3'h3 |=>
        (o_wb_data & 32'hF000_8040) == 32'h0) else $error("unused bits set");
    a_flag_sticky: assert property (o_dsp_status_control[22] && !i_status_wr |=>
        o_dsp_status_control[22]) else $error("flag cleared");
    a_sat_to_max: assert property (take && op == 3'h0 &&
        i_source_register[31:15] == 17'h0_FFFF |=> o_wb_data[31:16] == 16'h7FFF
        && o_dsp_status_control[22]) else $error("no saturation");
    cover property (take && op == 3'h0 ##1 o_dsp_status_control[22]);
    cover property (take ##1 take);
    cover property (take && op == 3'h3);
endmodule
bind dsp_pack_replicate_unit dsp_pack_props dsp_pack_props_inst (.i_sys_clk, .i_srst, .i_ce,
    .i_issue, .i_op, .i_source_register, .i_imm, .i_status_wr, .o_wb_valid, .o_wb_data,
    .o_dsp_status_control);

//--- testbench/core_wb_model.sv
`timescale 1ns/100ps
module core_wb_model (
    input wire logic i_sys_clk, // core clock
    input wire logic i_srst, // sync reset
    input wire logic i_ce, // clock enable
    input wire logic i_wb_valid, // result valid
    output int o_wb_count // register writes taken
);
    // one register-file write per valid, enabled cycle
    always_ff @(posedge i_sys_clk)
        o_wb_count <= i_srst ? 0 : o_wb_count + int'(i_wb_valid && i_ce);
endmodule

//--- testbench/dsp_pack_replicate_unit_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module dsp_pack_replicate_unit_tb_top;
    logic i_sys_clk = 0, i_srst = 1, i_ce = 1, i_issue = 0, i_mask_default = 0, i_status_wr = 0;
    dsp_pack_pkg::op_t i_op = dsp_pack_pkg::OP_ROUND_SAT_REDUCE;
    logic [31:0] i_source_register = 0, i_target_register = 0, i_status_wdata = 0;
    logic [31:0] o_wb_data, o_dsp_status_control;
    logic [4:0] i_shift_amount = 0;
    logic [9:0] i_imm = 0;
    logic o_wb_valid;
    int fail_count = 0, compares = 0, cycles = 0, issues = 0, wb_count;
    logic [31:0] fld [6] = '{32'h0000_003F, 32'h0000_1F80, 32'h0000_2000, 32'h00FF_0000,
        32'h0F00_0000, 32'h0000_4000};
    dsp_pack_replicate_unit dsp_pack_replicate_unit_inst (.i_sys_clk, .i_srst, .i_ce, .i_issue,
        .i_op, .i_source_register, .i_target_register, .i_shift_amount, .i_imm, .i_mask_default,
        .i_status_wr, .i_status_wdata, .o_wb_valid, .o_wb_data, .o_dsp_status_control);
    core_wb_model core_wb_model_inst (.i_sys_clk, .i_srst, .i_ce, .i_wb_valid(o_wb_valid),
        .o_wb_count(wb_count));
    always #2 i_sys_clk = ~i_sys_clk;
    // cut a hang short
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // issue one op, check its write-back one edge later
    task automatic run(logic [2:0] op, logic [31:0] s, t, logic [4:0] sa, logic [9:0] m,
        logic md, logic [31:0] e);
        {i_issue, i_source_register, i_target_register} = {1'h1, s, t};
        {i_shift_amount, i_imm, i_mask_default} = {sa, m, md};
        i_op = dsp_pack_pkg::op_t'(op);
        issues++;
        @(posedge i_sys_clk);
        #1;
        `CHK("wb_valid", 1'h1, o_wb_valid)
        `CHK("wb_data", e, o_wb_data)
    endtask
    // core write of the status register
    task automatic stat(logic [31:0] v);
        {i_issue, i_status_wr, i_status_wdata} = {1'h0, 1'h1, v};
        @(posedge i_sys_clk);
        #1;
        i_status_wr = 0;
        `CHK("status", v, o_dsp_status_control)
    endtask
    initial begin
        repeat (10) @(posedge i_sys_clk);
        #1;
        i_srst = 0;
        `CHK("reset status", 32'h0, o_dsp_status_control)
        run(3'h0, 32'h1234_7FFF, 32'hFFFF_8000, 5'h0, 10'h0, 1'h0, 32'h1234_0000);
        `CHK("no flag", 32'h0, o_dsp_status_control)
        run(3'h0, 32'h7FFF_8000, 32'h0001_2345, 5'h0, 10'h0, 1'h0, 32'h7FFF_0001);
        `CHK("flag", 32'h0040_0000, o_dsp_status_control)
        run(3'h1, 32'hB, 32'h8765_4321, 5'h4, 10'h0, 1'h0, 32'hB876_5432);
        run(3'h1, 32'hB, 32'h8765_4321, 5'h1F, 10'h0, 1'h0, 32'h17);
        run(3'h2, 32'hFFFF_FFFF, 32'h0, 5'h0, 10'h0, 1'h0, 32'h3FC);
        run(3'h4, 32'h0, 32'h0, 5'h0, 10'h200, 1'h0, 32'hFE00_FE00);
        run(3'h4, 32'h0, 32'h0, 5'h0, 10'h1FF, 1'h0, 32'h01FF_01FF);
        run(3'h5, 32'h0, 32'h0, 5'h0, 10'h3A5, 1'h0, 32'hA5A5_A5A5);
        run(3'h6, 32'hDEAD_BEEF, 32'h0, 5'h0, 10'h0, 1'h0, 32'hBEEF_BEEF);
        run(3'h7, 32'hDEAD_BEEF, 32'h0, 5'h0, 10'h0, 1'h0, 32'hEFEF_EFEF);
        `CHK("flag kept", 32'h0040_0000, o_dsp_status_control)
        stat(32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++) begin
            run(3'h3, 32'h0, 32'h0, 5'h0, 10'h3C0 | 10'(1 << i), 1'h0, fld[i]);
        end
        run(3'h3, 32'h0, 32'h0, 5'h0, 10'h0, 1'h1, 32'h0FFF_3FBF);
        // an issue while the enable is low must leave the write-back outputs frozen
        i_ce = 0;
        i_source_register = 32'h1111_1111;
        i_op = dsp_pack_pkg::OP_BYTE_REG_REPLICATE;
        @(posedge i_sys_clk);
        #1;
        `CHK("frozen data", 32'h0FFF_3FBF, o_wb_data)
        `CHK("frozen valid", 1'h1, o_wb_valid)
        {i_ce, i_issue} = 2'h2;
        @(posedge i_sys_clk);
        #1;
        `CHK("valid drops", 1'h0, o_wb_valid)
        `CHK("wb count", issues, wb_count)
        // a second reset in mid-run clears the status word again
        i_srst = 1;
        @(posedge i_sys_clk);
        #1;
        `CHK("status after reset", 32'h0, o_dsp_status_control)
        `CHK("data after reset", 32'h0, o_wb_data)
        test_done();
    end
endmodule
